// ===== rtl/pwm_top.sv
/*
 multi_channel_pwm_generator: timer with seven match registers, shadowed match
 values and six pwm outputs.
 assumes: control arrives as plain ports from logic on i_clk.
*/
// Function
// - prescaler divides the clock, feeding a 32-bit counter as time base
// - seven match registers compare against the counter and flag matches
// - cycle match resets the counter, setting the period
// - single-edge output rises at cycle start, falls at its own match
// - single-edge output set constant low never rises
// - double-edge output uses two matches for set and clear positions
// - rising before falling gives positive pulse, otherwise negative
// - six outputs, each single or double edge, in any mix
// - each match may continue, stop or reset counter, optional interrupt
// - all outputs share one repetition rate
// - any counter value is accepted for period and width
// - in pwm mode, released match values apply only at a cycle boundary while the counter runs
// - without pwm mode the block is a plain match timer
// - all match flags combine onto one interrupt line
`timescale 1ns/100ps
module multi_channel_pwm_generator #(
    parameter int unsigned NM = pwm_pkg::NUM_MATCH,
    parameter int unsigned NO = pwm_pkg::NUM_OUT
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_counter_enable,
    input  wire logic              i_pwm_mode,
    input  wire logic [31:0]       i_prescale,
    input  wire logic [NM*32-1:0]  i_match,
    input  wire logic [NM-1:0]     i_match_we,
    input  wire logic [NM-1:0]     i_match_release,
    input  wire logic [NM*3-1:0]   i_match_ctl,
    input  wire logic [NO-1:0]     i_out_enable,
    input  wire logic [NO-1:0]     i_double_edge,
    input  wire logic [NO-1:0]     i_const_low,
    input  wire logic [NM-1:0]     i_irq_clear,
    output logic      [NO-1:0]     o_pwm,
    output logic      [NM-1:0]     o_irq_flags,
    output logic                   o_irq,
    output logic                   o_running,
    output logic      [31:0]       o_count,
    output logic      [NM-1:0]     o_release_pending
);
    ////////////////////////////////////////////////////////////////////////////
    // match staging: written values wait in staging until released and, in
    // pwm mode while running, until the next cycle boundary
    logic [NM*32-1:0] stage_reg;
    logic [NM*32-1:0] active_reg;
    logic [NM-1:0]    pend_reg;
    logic             run_reg;
    logic             stop_hit;
    logic [NO-1:0]    level;
    logic [NM-1:0]    flag_reg;
    logic [NM-1:0]    flag_next;
    logic [NM-1:0]    irq_en;
    logic             load_now;
    pwm_match_if      mif();

    // outside pwm mode the block is a plain timer, values take effect at once
    assign load_now = !i_pwm_mode || mif.cycle_start || !run_reg;

    genvar g;
    generate
        for (g = 0; g < NM; g++) begin : g_shadow
            always_ff @(posedge i_clk) begin
                if (!i_reset_n) begin
                    stage_reg[g*32 +: 32]  <= pwm_pkg::MATCH_RESET;
                    active_reg[g*32 +: 32] <= pwm_pkg::MATCH_RESET;
                    pend_reg[g]            <= 1'b0;
                end else begin
                    if (i_match_we[g]) begin
                        stage_reg[g*32 +: 32] <= i_match[g*32 +: 32];
                    end
                    if (pend_reg[g] && load_now) begin
                        active_reg[g*32 +: 32] <= stage_reg[g*32 +: 32];
                        pend_reg[g]            <= i_match_release[g];
                    end else if (i_match_release[g]) begin
                        pend_reg[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // counter run state; a stop match clears run until i_counter_enable rises again
    logic en_d_reg;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            run_reg  <= 1'b0;
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= i_counter_enable;
            if (stop_hit || !i_counter_enable) begin
                run_reg <= 1'b0;
            end else if (i_counter_enable && !en_d_reg) begin
                run_reg <= 1'b1;
            end
        end
    end

    pwm_timebase #(
        .NM (NM)
    ) u_timebase (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_run      (run_reg),
        .i_prescale (i_prescale),
        .i_match    (active_reg),
        .i_mctl     (i_match_ctl),
        .o_stop     (stop_hit),
        .mif        (mif.timebase)
    );

    pwm_outstage #(
        .NO (NO)
    ) u_outstage (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_double    (i_double_edge),
        .i_const_low (i_const_low),
        .o_level     (level),
        .mif         (mif.outstage)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sticky interrupt flags: a new hit beats a same-cycle clear
    generate
        for (g = 0; g < NM; g++) begin : g_irq
            assign irq_en[g]    = i_match_ctl[g*3 + pwm_pkg::MCTL_IRQ];
            assign flag_next[g] = (mif.hit[g] & irq_en[g]) | (flag_reg[g] & ~i_irq_clear[g]);
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            flag_reg          <= '0;
            o_irq             <= 1'b0;
            o_pwm             <= '0;
            o_running         <= 1'b0;
            o_count           <= pwm_pkg::TC_RESET;
            o_release_pending <= '0;
        end else begin
            flag_reg          <= flag_next;
            o_irq             <= |flag_next;
            // disabled channels hold low; the timer still runs use
            o_pwm             <= i_pwm_mode ? (level & i_out_enable) : '0;
            o_running         <= run_reg;
            o_count           <= mif.count;
            o_release_pending <= pend_reg;
        end
    end
    assign o_irq_flags = flag_reg;
endmodule

// ===== rtl/pwm_pkg.sv
/*
 pwm_pkg: shared constants and types for the multi-channel pwm generator.
 assumes: one 100 MHz clock, synchronous active-low reset.
*/
package pwm_pkg;
    localparam int unsigned NUM_MATCH     = 7;
    localparam int unsigned NUM_OUT       = 6;
    localparam int unsigned CNT_W         = 32;
    localparam logic [31:0] TC_RESET      = 32'h0000_0000;
    localparam logic [31:0] PRESCALE_RST  = 32'h0000_0000;
    localparam logic [31:0] MATCH_RESET   = 32'h0000_0000;
    // per-match control field positions
    localparam int unsigned MCTL_IRQ      = 0;
    localparam int unsigned MCTL_RESET    = 1;
    localparam int unsigned MCTL_STOP     = 2;
    localparam int unsigned MCTL_W        = 3;
    localparam int unsigned CYCLE_IDX     = 0;
    localparam logic [2:0]  MCTL_RST_VAL  = 3'h0;
endpackage

// ===== rtl/pwm_match_if.sv
/*
 pwm_match_if: carries the counter, match hits and cycle boundary between
 the timebase and the output stage.
 assumes: both ends on the same clock.
*/
`timescale 1ns/100ps
interface pwm_match_if;
    logic [31:0] count;
    logic [6:0]  hit;
    logic        tick;
    logic        cycle_start;
    modport timebase (output count, output hit, output tick, output cycle_start);
    modport outstage (input count, input hit, input tick, input cycle_start);
endinterface

// ===== rtl/pwm_timebase.sv
/*
 pwm_timebase: prescaler, 32-bit counter and seven comparators.
 assumes: shadow match values are already latched by the top.
*/
`timescale 1ns/100ps
module pwm_timebase #(
    parameter int unsigned NM = 7
) (
    input  wire logic                i_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_run,
    input  wire logic [31:0]         i_prescale,
    input  wire logic [NM*32-1:0]    i_match,
    input  wire logic [NM*3-1:0]     i_mctl,
    output logic                     o_stop,
    pwm_match_if.timebase            mif
);
    logic [31:0]   pc_reg;
    logic [31:0]   tc_reg;
    logic          tick;
    logic [NM-1:0] eq;
    logic          do_reset;
    logic          do_stop;

    assign tick = i_run && (pc_reg == i_prescale);
    genvar g;
    generate
        for (g = 0; g < NM; g++) begin : g_cmp
            assign eq[g] = (tc_reg == i_match[g*32 +: 32]);
        end
    endgenerate
    always_comb begin
        do_reset = 1'b0;
        do_stop  = 1'b0;
        for (int k = 0; k < NM; k++) begin
            do_reset = do_reset | (eq[k] & i_mctl[k*3 + pwm_pkg::MCTL_RESET]);
            do_stop  = do_stop  | (eq[k] & i_mctl[k*3 + pwm_pkg::MCTL_STOP]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_run) begin
            pc_reg <= pwm_pkg::PRESCALE_RST;
        end else if (tick) begin
            pc_reg <= pwm_pkg::PRESCALE_RST;
        end else begin
            pc_reg <= pc_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            tc_reg <= pwm_pkg::TC_RESET;
        end else if (tick) begin
            // a match-reset wins over counting so the period is match+1 ticks
            tc_reg <= do_reset ? pwm_pkg::TC_RESET : tc_reg + 32'h0000_0001;
        end
    end

    assign o_stop          = tick & do_stop;
    assign mif.count       = tc_reg;
    assign mif.hit         = tick ? 7'(eq) : 7'h00;
    assign mif.tick        = tick;
    assign mif.cycle_start = tick & eq[pwm_pkg::CYCLE_IDX];
endmodule

// ===== rtl/pwm_outstage.sv
/*
 pwm_outstage: builds the six pwm levels from match hits.
 assumes: hit and cycle_start are one-cycle pulses from the timebase.
*/
`timescale 1ns/100ps
module pwm_outstage #(
    parameter int unsigned NO = 6
) (
    input  wire logic          i_clk,
    input  wire logic          i_reset_n,
    input  wire logic [NO-1:0] i_double,
    input  wire logic [NO-1:0] i_const_low,
    output logic      [NO-1:0] o_level,
    pwm_match_if.outstage      mif
);
    logic [NO-1:0] lvl_reg;
    logic [NO-1:0] lvl_next;
    logic [NO-1:0] set_ev;
    logic [NO-1:0] clr_ev;

    // output n: single edge sets at cycle start, clears on match n+1;
    // double edge sets on match n, clears on match n+1
    genvar g;
    generate
        for (g = 0; g < NO; g++) begin : g_out
            assign set_ev[g] = i_double[g] ? mif.hit[g] : (mif.cycle_start & ~i_const_low[g]);
            assign clr_ev[g] = mif.hit[g+1] | (i_const_low[g] & ~i_double[g]);
            // clear wins a tie so a zero-width pulse stays low
            assign lvl_next[g] = clr_ev[g] ? 1'b0 : (set_ev[g] ? 1'b1 : lvl_reg[g]);
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            lvl_reg <= '0;
        end else begin
            lvl_reg <= lvl_next;
        end
    end
    assign o_level = lvl_reg;
endmodule

// ===== test/pwm_gen_chk.sv
/*
 pwm_gen_chk: concurrent checks on the pwm generator's top ports.
 assumes: bound into the top, one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module pwm_gen_chk #(
    parameter int unsigned NM = 7,
    parameter int unsigned NO = 6
) (
    input wire logic          i_clk,
    input wire logic          i_reset_n,
    input wire logic          i_pwm_mode,
    input wire logic [31:0]   i_prescale,
    input wire logic [NM-1:0] i_match_we,
    input wire logic [NM-1:0] i_match_release,
    input wire logic [NO-1:0] i_double_edge,
    input wire logic [NO-1:0] i_const_low,
    input wire logic [NM-1:0] i_irq_clear,
    input wire logic [NO-1:0] o_pwm,
    input wire logic [NM-1:0] o_irq_flags,
    input wire logic          o_irq,
    input wire logic          o_running,
    input wire logic [31:0]   o_count,
    input wire logic [NM-1:0] o_release_pending
);
    logic [31:0] cnt_reg;
    logic [31:0] gap_reg;
    logic        valid_reg;
    wire         count_moved = (o_count != cnt_reg);
    // spacing is only trusted once two steps were seen in one run
    always_ff @(posedge i_clk) begin
        cnt_reg <= o_count;
        gap_reg <= count_moved ? 32'h0 : gap_reg + 32'h1;
        valid_reg <= i_reset_n && o_running && (valid_reg || count_moved);
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_hold_count;
        $stable(o_count) [*3];
    endsequence
    sequence s_pending_up;
        ##[1:2] o_release_pending[1];
    endsequence
    a_count_step: assert property (count_moved |-> o_count == cnt_reg + 32'h1 || o_count == 32'h0)
        else $error("count moved by more than one step");
    a_prescale_gap: assert property (count_moved && valid_reg && o_running |-> gap_reg == i_prescale)
        else $error("count step spacing differs from prescale");
    a_irq_or: assert property (o_irq == |o_irq_flags)
        else $error("irq line differs from or of flags");
    a_flag_sticky: assert property ((($past(o_irq_flags) & ~o_irq_flags & ~$past(i_irq_clear)) == 7'h0))
        else $error("flag dropped without clear");
    a_const_low: assert property ((o_pwm & ~$past(o_pwm) & $past(i_const_low & ~i_double_edge)) == 6'h0)
        else $error("constant low output rose");
    a_single_rise: assert property (|(o_pwm & ~$past(o_pwm) & ~$past(i_double_edge)) |->
        ##[0:2] o_count == 32'h0)
        else $error("single edge output rose away from cycle start");
    a_stop_hold: assert property ($fell(o_running) |=> s_hold_count)
        else $error("count moved after stop");
    // a release always shows as pending, even when it loads on the next edge
    a_pending_set: assert property (i_match_release[1] && i_pwm_mode && o_running |-> s_pending_up)
        else $error("released value not shown pending");
    // a running pwm load may only land on the cycle match, so the count restarts
    a_load_boundary: assert property ($fell(o_release_pending[1]) && i_pwm_mode && $past(o_running) |->
        o_count == 32'h0)
        else $error("running pwm load away from cycle start");
endmodule

// ===== test/pwm_load_model.sv
/*
 pwm_load_model: the loads on the six pwm pins; counts high cycles and
 rising edges while the measure window is open, clears when it closes.
 assumes: pins sampled on the design clock.
*/
`timescale 1ns/100ps
module pwm_load_model (
    input  wire logic       i_clk,
    input  wire logic       i_measure,
    input  wire logic [5:0] i_pwm,
    output int              o_high [6],
    output int              o_rise [6]
);
    logic [5:0] prev_reg;
    always @(posedge i_clk) begin
        prev_reg <= i_pwm;
        for (int n = 0; n < 6; n++) begin
            o_high[n] <= i_measure ? o_high[n] + int'(i_pwm[n]) : 0;
            o_rise[n] <= i_measure ? o_rise[n] + int'(i_pwm[n] & ~prev_reg[n]) : 0;
        end
    end
endmodule

// ===== test/testbench.sv
/*
 testbench: drives the pwm generator, measures its pins with the load model
 and compares with a behavioural model of the match rules.
 assumes: 100 MHz clock, inputs changed 1 ns after the rising edge.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    logic         clk, reset_n, cnt_en, pwm_mode, irq, running, meas;
    logic [31:0]  prescale, count;
    logic [223:0] match;
    logic [20:0]  match_ctl;
    logic [6:0]   match_we, match_rel, irq_clr, flags, pending;
    logic [5:0]   dbl, cl, pwm, oe;
    int           failures, total_checks, cycles, p_cur, v, hi[6], ri[6], m[7];
    int           seed = 32'h8714;
    multi_channel_pwm_generator u_multi_channel_pwm_generator (.i_clk(clk), .i_reset_n(reset_n),
        .i_counter_enable(cnt_en), .i_pwm_mode(pwm_mode), .i_prescale(prescale), .i_match(match),
        .i_match_we(match_we), .i_match_release(match_rel), .i_match_ctl(match_ctl), .i_out_enable(oe),
        .i_double_edge(dbl), .i_const_low(cl), .i_irq_clear(irq_clr), .o_pwm(pwm), .o_irq_flags(flags),
        .o_irq(irq), .o_running(running), .o_count(count), .o_release_pending(pending));
    pwm_load_model u_pwm_load_model (.i_clk(clk), .i_measure(meas), .i_pwm(pwm), .o_high(hi), .o_rise(ri));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic load_all();
        for (int k = 0; k < 7; k++) match[k*32+:32] = m[k];
        match_we = 7'h7f;
        step(1);
        match_we = 7'h0;
        match_rel = 7'h7f;
        step(1);
        match_rel = 7'h0;
    endtask
    // high cycles per period; ties between set and clear leave the pin low
    function automatic int eh(input int n);
        int q, a, b;
        q = p_cur + 1;
        a = dbl[n] ? m[n] : m[0];
        b = m[n+1];
        if (!oe[n]) return 0;
        if (!dbl[n]) return cl[n] ? 0 : (b + 1) * q;
        return (a < b) ? (b - a) * q : (a == b) ? 0 : (m[0] + 1 - a + b) * q;
    endfunction
    task automatic measure(input int k);
        int per, h;
        per = (m[0] + 1) * (p_cur + 1);
        meas = 1;
        step(k * per);
        meas = 0;
        for (int n = 0; n < 6; n++) begin
            h = eh(n);
            `CHK("high time", k * h, hi[n])
            `CHK("rises", (h > 0 && h < per) ? k : 0, ri[n])
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {meas, match, match_we, match_rel, irq_clr, pwm_mode} = '0;
        for (int r = 0; r < 4; r++) begin
            reset_n = 0;
            cnt_en = 0;
            pwm_mode = 1;
            p_cur = r % 3;
            prescale = p_cur;
            // one pass masks random channels, the others enable all six
            oe = (r == 2) ? 6'($random(seed)) : 6'h3f;
            dbl = (r == 0) ? 6'h0a : 6'($random(seed));
            cl = ((r == 0) ? 6'h05 : 6'($random(seed))) & ~dbl;
            m[0] = 9;
            for (int k = 1; k < 7; k++) m[k] = 1 + ($random(seed) & 7);
            match_ctl = 21'h3;
            step(3);
            reset_n = 1;
            load_all();
            cnt_en = 1;
            step(60);
            measure(2);
            `CHK("flag0", 1'b1, flags[0])
        end
        // a write alone is only staged; pending shows released values awaiting the cycle match
        v = (m[1] == 8) ? 1 : m[1] + 1;
        match[32+:32] = v;
        match_we = 7'h02;
        step(1);
        match_we = 7'h0;
        step(3);
        `CHK("pending", 1'b0, pending[1])
        measure(2);
        match_rel = 7'h02;
        step(1);
        match_rel = 7'h0;
        m[1] = v;
        step(1);
        `CHK("pending", 1'b1, pending[1])
        step(60);
        `CHK("pending", 1'b0, pending[1])
        measure(2);
        reset_n = 0;
        cnt_en = 0;
        pwm_mode = 0;
        p_cur = 2;
        prescale = 2;
        m = '{9, 8, 8, 8, 8, 8, 5};
        match_ctl = {3'h5, 15'h0, 3'h2};
        step(3);
        reset_n = 1;
        load_all();
        cnt_en = 1;
        step(60);
        `CHK("running", 1'b0, running)
        // the stop tick itself still advances the count once before the hold
        `CHK("count", 32'h6, count)
        `CHK("pwm off", 6'h0, pwm)
        `CHK("flags", 7'h40, flags)
        `CHK("irq", 1'b1, irq)
        irq_clr = 7'h40;
        step(1);
        irq_clr = 7'h0;
        step(2);
        `CHK("flags", 7'h0, flags)
        `CHK("irq", 1'b0, irq)
        report_and_stop();
    end
endmodule
bind multi_channel_pwm_generator pwm_gen_chk #(.NM(NM), .NO(NO)) u_pwm_gen_chk (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_pwm_mode(i_pwm_mode), .i_prescale(i_prescale), .i_match_we(i_match_we),
    .i_match_release(i_match_release), .i_double_edge(i_double_edge), .i_const_low(i_const_low),
    .i_irq_clear(i_irq_clear), .o_pwm(o_pwm), .o_irq_flags(o_irq_flags), .o_irq(o_irq),
    .o_running(o_running), .o_count(o_count), .o_release_pending(o_release_pending));
